// file: setup_delete_and_default_restore_tb.sv
// Testbench for setup delete and default restore
`timescale 1ns/1ps

module setup_delete_and_default_restore_tb;
	localparam logic [7:0] CFG_A [9] = '{8'h10, 8'h14, 8'h18, 8'h1C,
		8'h20, 8'h24, 8'h28, 8'h2C, 8'h30};
	localparam logic [31:0] CFG_E [9] = '{{19'h0, smd_pkg::MODE_DFLT},
		32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00000100, 32'h0, 32'h105};
	logic sys_clk;
	logic srst;
	logic bus_clear;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic display_blank;
	logic busy;
	logic [31:0] relay_xp;
	logic [15:0] dig_out;
	smd_pkg::smd_mode_t mode_out;
	logic [31:0] d;
	bit ok;
	int errors;
	int n_tests;

	smd_setup_ctl dut_u (.sys_clk(sys_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_clear(bus_clear),
		.display_blank(display_blank), .busy(busy), .relay_xp(relay_xp),
		.dig_out(dig_out), .mode_out(mode_out));

	smd_host_model host_u (.sys_clk(sys_clk), .busy(busy),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic chk(input string name, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic rdchk(input string name, input logic [7:0] a,
		input logic [31:0] e);
		host_u.rd(a, d);
		chk(name, e, d);
	endtask

	task automatic idle();
		host_u.wait_idle(ok);
		if (!ok) begin
			errors++;
			$display("mismatch busy expected 0 seen 1");
		end
	endtask

	task automatic cmd(input logic [1:0] op, input logic [7:0] p);
		host_u.wr(smd_pkg::OFS_CMD, {22'h0, op, p});
	endtask

	task automatic mem_put(input int k, input logic [31:0] v);
		host_u.wr(smd_pkg::OFS_SEL, k);
		host_u.wr(smd_pkg::OFS_DATA, v);
	endtask

	task automatic mem_chk(input int k, input logic [31:0] e);
		host_u.wr(smd_pkg::OFS_SEL, k);
		rdchk("setup", smd_pkg::OFS_DATA, e);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#400000;
		errors++;
		end_of_test();
	end

	initial begin
		srst = 1'b1;
		bus_clear = 1'b0;
		errors = 0;
		n_tests = 0;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		idle();
		chk("mode", CFG_E[0], {19'h0, mode_out});
		chk("dout", 32'h0, {16'h0, dig_out});
		$display("test reset done");
		for (int k = 1; k <= 100; k++) mem_put(k, k);
		cmd(smd_pkg::OP_DELETE, 8'h32);
		#1;
		chk("blank", 32'h1, {31'h0, display_blank});
		idle();
		chk("blank", 32'h0, {31'h0, display_blank});
		for (int k = 1; k < 50; k++) mem_chk(k, k);
		for (int k = 50; k < 100; k++) mem_chk(k, k + 1);
		mem_chk(100, 32'h0);
		$display("test delete done");
		mem_put(100, 32'hA5A5A5A5);
		cmd(smd_pkg::OP_DELETE, 8'h64);
		#1;
		chk("busy", 32'h1, {31'h0, busy});
		@(posedge sys_clk);
		#1;
		chk("busy", 32'h0, {31'h0, busy});
		mem_chk(99, 32'h64);
		mem_chk(100, 32'h0);
		$display("test delete top done");
		cmd(smd_pkg::OP_DELETE, 8'h00);
		rdchk("status", smd_pkg::OFS_STATUS, 32'h2);
		host_u.wr(smd_pkg::OFS_STATUS, 32'h2);
		rdchk("status", smd_pkg::OFS_STATUS, 32'h0);
		cmd(smd_pkg::OP_DELETE, 8'h65);
		rdchk("status", smd_pkg::OFS_STATUS, 32'h2);
		mem_chk(99, 32'h64);
		$display("test range done");
		for (int i = 0; i < 8; i++) host_u.wr(CFG_A[i], 32'hFFFFFFFF);
		host_u.wr(smd_pkg::OFS_ADDR, 32'h105);
		host_u.wr(smd_pkg::OFS_STATUS, 32'h2);
		cmd(smd_pkg::OP_RESTORE, smd_pkg::RESTORE_PARAM);
		cmd(smd_pkg::OP_DELETE, 8'h01);
		idle();
		rdchk("status", smd_pkg::OFS_STATUS, 32'h2);
		rdchk("mode", CFG_A[0], CFG_E[0]);
		rdchk("srq", CFG_A[1], CFG_E[1]);
		rdchk("dout", CFG_A[2], CFG_E[2]);
		rdchk("settle", CFG_A[3], CFG_E[3]);
		rdchk("mb_rows", CFG_A[4], CFG_E[4]);
		rdchk("bm_rows", CFG_A[5], CFG_E[5]);
		rdchk("step", CFG_A[6], CFG_E[6]);
		rdchk("relay_reg", CFG_A[7], CFG_E[7]);
		rdchk("addr", CFG_A[8], CFG_E[8]);
		chk("trig_edge", 32'h1, {31'h0, mode_out.trig_falling});
		chk("settled", 32'h1, {31'h0, mode_out.settled_neg});
		chk("format", 32'h1, {31'h0, mode_out.full_fmt});
		chk("eoi", 32'h1, {31'h0, mode_out.eoi_hold});
		chk("trig_src", 32'h7, {29'h0, mode_out.trig_src});
		chk("term", 32'h0, {30'h0, mode_out.term_sel});
		chk("trig_en", 32'h0, {31'h0, mode_out.trig_en});
		chk("unspec", 32'h0, {29'h0, mode_out.unspec});
		chk("relay", 32'h0, relay_xp);
		chk("dout", 32'h0, {16'h0, dig_out});
		for (int k = 1; k <= 100; k++) mem_chk(k, 32'h0);
		$display("test restore done");
		mem_put(3, 32'h5A);
		host_u.wr(smd_pkg::OFS_DOUT, 32'hBEEF);
		host_u.wr(smd_pkg::OFS_STEP, 32'h0305);
		@(posedge sys_clk);
		bus_clear <= 1'b1;
		@(posedge sys_clk);
		bus_clear <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("dout", 32'h0, {16'h0, dig_out});
		rdchk("step", smd_pkg::OFS_STEP, 32'h100);
		mem_chk(3, 32'h5A);
		$display("test clear done");
		end_of_test();
	end
endmodule

// file: smd_host_model.sv
// Register bus master standing in for the bus controller
`timescale 1ns/1ps

module smd_host_model (
	// Clock and status
	input wire logic sys_clk,
	input wire logic busy,
	// Register port
	output logic [7:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Released lines show inverse
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask

	task automatic wait_idle(output bit ok);
		ok = 1'b0;
		for (int i = 0; i < 400 && !ok; i++) begin
			@(posedge sys_clk);
			#1;
			ok = (busy === 1'b0);
		end
	endtask
endmodule

// file: smd_pkg.sv
// Constants, types and defaults for the setup delete and restore block
package smd_pkg;

	// Setup memory geometry
	localparam int XP_W = 32;
	localparam logic [6:0] SLOT_MIN = 7'h01;
	localparam logic [6:0] SLOT_MAX = 7'h64;
	localparam logic [6:0] SLOT_LAST_SRC = 7'h63;

	// Command opcodes and parameters
	localparam logic [1:0] OP_DELETE = 2'h1;
	localparam logic [1:0] OP_RESTORE = 2'h2;
	localparam logic [7:0] RESTORE_PARAM = 8'h00;

	// Register offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SEL = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0C;
	localparam logic [7:0] OFS_MODE = 8'h10;
	localparam logic [7:0] OFS_SRQ = 8'h14;
	localparam logic [7:0] OFS_DOUT = 8'h18;
	localparam logic [7:0] OFS_SETTLE = 8'h1C;
	localparam logic [7:0] OFS_MBROWS = 8'h20;
	localparam logic [7:0] OFS_BMROWS = 8'h24;
	localparam logic [7:0] OFS_STEP = 8'h28;
	localparam logic [7:0] OFS_RELAY = 8'h2C;
	localparam logic [7:0] OFS_ADDR = 8'h30;

	// Status field positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_ERR = 1;
	localparam int STAT_BLANK = 2;

	// Operating mode settings
	typedef struct packed {
		logic trig_falling;
		logic settled_neg;
		logic full_fmt;
		logic eoi_hold;
		logic trig_en;
		logic [2:0] trig_src;
		logic [1:0] term_sel;
		logic [2:0] unspec;
	} smd_mode_t;

	// Numeric parameter settings
	typedef struct packed {
		logic [7:0] srq_mask;
		logic [15:0] dout;
		logic [15:0] settle_ms;
		logic [31:0] mb_rows;
		logic [31:0] bm_rows;
	} smd_parm_t;

	// Command word in the low bits of a command write
	typedef struct packed {
		logic [1:0] op;
		logic [7:0] param;
	} smd_cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01,
		ST_CLRTOP = 2'b10,
		ST_CLRALL = 2'b11
	} smd_state_t;

	// Reset and restore values
	localparam smd_mode_t MODE_DFLT = '{
		trig_falling: 1'b1,
		settled_neg: 1'b1,
		full_fmt: 1'b1,
		eoi_hold: 1'b1,
		trig_en: 1'b0,
		trig_src: 3'h7,
		term_sel: 2'h0,
		unspec: 3'h0
	};
	localparam smd_parm_t PARM_DFLT = '{
		srq_mask: 8'h00,
		dout: 16'h0000,
		settle_ms: 16'h0000,
		mb_rows: 32'h00000000,
		bm_rows: 32'h00000000
	};
	localparam logic [7:0] RSTEP_DFLT = 8'h00;
	localparam logic [7:0] MSTEP_DFLT = 8'h01;
	localparam logic [4:0] PADDR_DFLT = 5'h12;
	localparam logic MS_DFLT = 1'b0;

endpackage

// file: smd_setup_ctl.sv
// Setup delete and default restore command execution
//
// What this block does
// - Delete accepts setup numbers 1 to 100
// - Delete shifts higher setups down one slot
// - Top setup slot cleared after shift
// - Display blanked while delete runs
// - Deleting setup 100 only clears it
// - Restore clears every stored setup
// - Restore clears both row selection sets
// - Restore opens relays, steps to 000/001
// - Restore selects falling trigger edge
// - Restore makes settled output active low
// - Restore selects full output format
// - Restore sets EOI and execute holdoff
// - Restore clears the SRQ source mask
// - Restore drives all digital outputs low
// - Restore zeroes added settling time
// - Restore selects external trigger source
// - Restore zeroes both row masks
// - Restore selects CR LF terminator
// - Restore keeps address and master/slave
// - Restore leaves triggering disabled
// - Defaults also at reset and bus clear; bus clear keeps stored setups
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps

module smd_setup_ctl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Universal clear pulse
	input wire logic bus_clear,
	// Instrument outputs
	output logic display_blank,
	output logic busy,
	output logic [31:0] relay_xp,
	output logic [15:0] dig_out,
	output smd_pkg::smd_mode_t mode_out
);

	smd_pkg::smd_state_t state_ff, nxt_state;
	logic [6:0] idx_ff, nxt_idx;
	logic [6:0] sel_ff;
	logic [6:0] idx_p1;
	logic [31:0] mem [1:100];
	smd_pkg::smd_mode_t mode_ff;
	smd_pkg::smd_parm_t parm_ff;
	logic [31:0] relay_ff;
	logic [7:0] rstep_ff;
	logic [7:0] mstep_ff;
	logic [4:0] paddr_ff;
	logic ms_ff;
	logic err_ff;
	logic busy_ff;
	logic blank_ff;
	logic [31:0] rdata_ff;
	smd_pkg::smd_cmd_t cmd;
	logic idle;
	logic cmd_wr;
	logic del_go;
	logic rst_go;
	logic bad_cmd;
	logic cfg_wr;
	logic defaults_go;
	logic sel_ok;

	assign cmd = smd_pkg::smd_cmd_t'(reg_wdata[9:0]);
	assign idle = (state_ff == smd_pkg::ST_IDLE);
	assign cmd_wr = reg_wr && (reg_addr == smd_pkg::OFS_CMD);
	assign del_go = cmd_wr && idle && (cmd.op == smd_pkg::OP_DELETE) &&
		(cmd.param >= {1'b0, smd_pkg::SLOT_MIN}) &&
		(cmd.param <= {1'b0, smd_pkg::SLOT_MAX});
	assign rst_go = cmd_wr && idle && (cmd.op == smd_pkg::OP_RESTORE) &&
		(cmd.param == smd_pkg::RESTORE_PARAM);
	assign bad_cmd = cmd_wr && !(del_go || rst_go);
	assign cfg_wr = reg_wr && idle;
	assign defaults_go = srst || bus_clear || rst_go;
	assign idx_p1 = idx_ff + smd_pkg::SLOT_MIN;
	assign sel_ok = (sel_ff >= smd_pkg::SLOT_MIN) &&
		(sel_ff <= smd_pkg::SLOT_MAX);

	// Sequencer next state
	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		unique case (state_ff)
			smd_pkg::ST_IDLE: begin
				if (del_go) begin
					if (cmd.param[6:0] == smd_pkg::SLOT_MAX) begin
						nxt_state = smd_pkg::ST_CLRTOP;
					end else begin
						nxt_state = smd_pkg::ST_SHIFT;
					end
					nxt_idx = cmd.param[6:0];
				end else if (rst_go) begin
					nxt_state = smd_pkg::ST_CLRALL;
					nxt_idx = smd_pkg::SLOT_MIN;
				end
			end
			smd_pkg::ST_SHIFT: begin
				nxt_idx = idx_p1;
				if (idx_ff == smd_pkg::SLOT_LAST_SRC) begin
					nxt_state = smd_pkg::ST_CLRTOP;
				end
			end
			smd_pkg::ST_CLRTOP: begin
				nxt_state = smd_pkg::ST_IDLE;
			end
			smd_pkg::ST_CLRALL: begin
				nxt_idx = idx_p1;
				if (idx_ff == smd_pkg::SLOT_MAX) begin
					nxt_state = smd_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// Sequencer state, memory swept clean after reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_ff <= smd_pkg::ST_CLRALL;
			idx_ff <= smd_pkg::SLOT_MIN;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
		end
	end

	// Setup memory
	always_ff @(posedge sys_clk) begin
		unique case (state_ff)
			smd_pkg::ST_SHIFT: begin
				mem[idx_ff] <= mem[idx_p1];
			end
			smd_pkg::ST_CLRTOP: begin
				mem[smd_pkg::SLOT_MAX] <= 32'h00000000;
			end
			smd_pkg::ST_CLRALL: begin
				mem[idx_ff] <= 32'h00000000;
			end
			smd_pkg::ST_IDLE: begin
				if (reg_wr && (reg_addr == smd_pkg::OFS_DATA) && sel_ok) begin
					mem[sel_ff] <= reg_wdata;
				end
			end
		endcase
	end

	// Setup select register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sel_ff <= smd_pkg::SLOT_MIN;
		end else if (reg_wr && (reg_addr == smd_pkg::OFS_SEL)) begin
			sel_ff <= reg_wdata[6:0];
		end
	end

	// Mode settings
	always_ff @(posedge sys_clk) begin
		if (defaults_go) begin
			mode_ff <= smd_pkg::MODE_DFLT;
		end else if (cfg_wr && (reg_addr == smd_pkg::OFS_MODE)) begin
			mode_ff <= smd_pkg::smd_mode_t'(reg_wdata[12:0]);
		end
	end

	// Numeric settings
	always_ff @(posedge sys_clk) begin
		if (defaults_go) begin
			parm_ff <= smd_pkg::PARM_DFLT;
		end else if (cfg_wr) begin
			unique case (reg_addr)
				smd_pkg::OFS_SRQ: parm_ff.srq_mask <= reg_wdata[7:0];
				smd_pkg::OFS_DOUT: parm_ff.dout <= reg_wdata[15:0];
				smd_pkg::OFS_SETTLE: parm_ff.settle_ms <= reg_wdata[15:0];
				smd_pkg::OFS_MBROWS: parm_ff.mb_rows <= reg_wdata;
				smd_pkg::OFS_BMROWS: parm_ff.bm_rows <= reg_wdata;
				default: parm_ff <= parm_ff;
			endcase
		end
	end

	// Present relays and step pointers
	always_ff @(posedge sys_clk) begin
		if (defaults_go) begin
			relay_ff <= 32'h00000000;
			rstep_ff <= smd_pkg::RSTEP_DFLT;
			mstep_ff <= smd_pkg::MSTEP_DFLT;
		end else if (cfg_wr && (reg_addr == smd_pkg::OFS_RELAY)) begin
			relay_ff <= reg_wdata;
		end else if (cfg_wr && (reg_addr == smd_pkg::OFS_STEP)) begin
			rstep_ff <= reg_wdata[7:0];
			mstep_ff <= reg_wdata[15:8];
		end
	end

	// Bus address and master/slave, untouched by restore
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			paddr_ff <= smd_pkg::PADDR_DFLT;
			ms_ff <= smd_pkg::MS_DFLT;
		end else if (cfg_wr && (reg_addr == smd_pkg::OFS_ADDR)) begin
			paddr_ff <= reg_wdata[4:0];
			ms_ff <= reg_wdata[8];
		end
	end

	// Sticky command error, set wins over clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			err_ff <= 1'b0;
		end else if (bad_cmd) begin
			err_ff <= 1'b1;
		end else if (reg_wr && (reg_addr == smd_pkg::OFS_STATUS) &&
			reg_wdata[smd_pkg::STAT_ERR]) begin
			err_ff <= 1'b0;
		end
	end

	// Busy and display blanking
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busy_ff <= 1'b1;
			blank_ff <= 1'b0;
		end else begin
			busy_ff <= (nxt_state != smd_pkg::ST_IDLE);
			blank_ff <= (nxt_state == smd_pkg::ST_SHIFT) ||
				(nxt_state == smd_pkg::ST_CLRTOP);
		end
	end

	// Read data, valid only in the cycle after a read
	always_ff @(posedge sys_clk) begin
		if (srst || !reg_rd) begin
			rdata_ff <= 32'h00000000;
		end else begin
			unique case (reg_addr)
				smd_pkg::OFS_STATUS: rdata_ff <= {29'h0, blank_ff, err_ff,
					busy_ff};
				smd_pkg::OFS_SEL: rdata_ff <= {25'h0, sel_ff};
				smd_pkg::OFS_DATA: rdata_ff <= sel_ok ? mem[sel_ff] :
					32'h00000000;
				smd_pkg::OFS_MODE: rdata_ff <= {19'h0, mode_ff};
				smd_pkg::OFS_SRQ: rdata_ff <= {24'h0, parm_ff.srq_mask};
				smd_pkg::OFS_DOUT: rdata_ff <= {16'h0, parm_ff.dout};
				smd_pkg::OFS_SETTLE: rdata_ff <= {16'h0, parm_ff.settle_ms};
				smd_pkg::OFS_MBROWS: rdata_ff <= parm_ff.mb_rows;
				smd_pkg::OFS_BMROWS: rdata_ff <= parm_ff.bm_rows;
				smd_pkg::OFS_STEP: rdata_ff <= {16'h0, mstep_ff, rstep_ff};
				smd_pkg::OFS_RELAY: rdata_ff <= relay_ff;
				smd_pkg::OFS_ADDR: rdata_ff <= {23'h0, ms_ff, 3'h0, paddr_ff};
				default: rdata_ff <= 32'h00000000;
			endcase
		end
	end

	assign reg_rdata = rdata_ff;
	assign display_blank = blank_ff;
	assign busy = busy_ff;
	assign relay_xp = relay_ff;
	assign dig_out = parm_ff.dout;
	assign mode_out = mode_ff;

	// Checking helpers
	logic [6:0] chk_idx_ff;
	logic [31:0] chk_val_ff;
	always_ff @(posedge sys_clk) begin
		chk_idx_ff <= idx_ff;
		chk_val_ff <= (idx_ff < smd_pkg::SLOT_MAX) ? mem[idx_p1] :
			32'h00000000;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence del_walk_s;
		(state_ff == smd_pkg::ST_SHIFT) ##1 (state_ff == smd_pkg::ST_CLRTOP);
	endsequence

	sequence clr_done_s;
		##100 (state_ff == smd_pkg::ST_IDLE) && !busy_ff;
	endsequence

	range_reject_a: assert property (
		(cmd_wr && idle && (cmd.op == smd_pkg::OP_DELETE) &&
		((cmd.param == 8'h00) || (cmd.param > 8'h64)))
		|=> (state_ff == smd_pkg::ST_IDLE) && err_ff)
		else $error("out of range delete was executed");

	shift_move_a: assert property (
		(state_ff == smd_pkg::ST_SHIFT) |=> (mem[chk_idx_ff] == chk_val_ff))
		else $error("setup not moved down one slot");

	top_clear_a: assert property (
		del_walk_s |=> (mem[smd_pkg::SLOT_MAX] == 32'h00000000) &&
		(state_ff == smd_pkg::ST_IDLE))
		else $error("top slot not cleared after shift");

	blank_delete_a: assert property (
		((state_ff == smd_pkg::ST_SHIFT) || (state_ff == smd_pkg::ST_CLRTOP))
		== blank_ff)
		else $error("display blank does not track delete");

	last_noshift_a: assert property (
		(del_go && (cmd.param == 8'h64))
		|=> (state_ff == smd_pkg::ST_CLRTOP) ##1 !blank_ff)
		else $error("deleting last setup did not just clear it");

	restore_sweep_a: assert property (
		rst_go |=> (state_ff == smd_pkg::ST_CLRALL) ##0 clr_done_s)
		else $error("restore memory sweep has wrong length");

	device_clear_a: assert property (
		rst_go |=> (relay_ff == 32'h00000000) && (rstep_ff == 8'h00) &&
		(mstep_ff == 8'h01))
		else $error("device clear not performed");

	mode_dflt_a: assert property (
		defaults_go |=> (mode_ff == smd_pkg::MODE_DFLT) &&
		(mode_ff.trig_src == 3'h7) && !mode_ff.trig_en)
		else $error("mode defaults not loaded");

	rows_clear_a: assert property (
		(rst_go || bus_clear) |=> (parm_ff.mb_rows == 32'h00000000) &&
		(parm_ff.bm_rows == 32'h00000000) && (parm_ff.dout == 16'h0000) &&
		(parm_ff.srq_mask == 8'h00) && (parm_ff.settle_ms == 16'h0000))
		else $error("numeric defaults not loaded");

	addr_keep_a: assert property (
		rst_go |=> $stable(paddr_ff) && $stable(ms_ff))
		else $error("restore changed address or master/slave");

	busy_hold_a: assert property (
		(!idle && cmd_wr) |=> err_ff &&
		($stable(mode_ff) || $past(bus_clear)))
		else $error("command taken while busy");

	blank_start_a: assert property (
		del_go |=> blank_ff && busy_ff)
		else $error("delete did not blank the display");

	restore_busy_a: assert property (
		rst_go |=> busy_ff && !blank_ff)
		else $error("restore did not hold off commands");

	clear_device_a: assert property (
		bus_clear |=> (relay_ff == 32'h00000000) &&
		(rstep_ff == smd_pkg::RSTEP_DFLT) &&
		(mstep_ff == smd_pkg::MSTEP_DFLT))
		else $error("bus clear did not clear the device");

	err_set_a: assert property (
		bad_cmd |=> err_ff)
		else $error("refused command did not set error");

endmodule
